// ==== rtl/prox_cal_pkg.sv ====
// Function
// - Raw 16-bit results readable from 0x00B onward
// - Per-stage results kept readable in third bank
// - Proximity check disables ambient calibration at once
// - Hold period from 4-bit counts at 0x002
// - Long proximity forces recalibration, delay at 0x004
// - Forced recalibration lasts two conversion cycles
// - Comparator one: fifo sample difference beyond rate
// - Comparator two: fast average versus ambient level
// - Compensation on each conversion while untouched
// - Ambient drift moves stage high/low thresholds
// - Ambient taken only when no approach or touch, or from fast average as forced recalibration ends
// - Slow filter updates when enabled and no proximity
// - Per-stage compensation data held in memory
// - Interrupt asserts when result passes a threshold
package prox_cal_pkg;

    // Geometry
    localparam int NUM_STAGES = 12;
    localparam int ADDR_W     = 10;
    localparam int DATA_W     = 16;

    // Bank 1 control and raw result register offsets
    localparam logic [ADDR_W-1:0] ADDR_HOLD      = 10'h002;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL     = 10'h003;
    localparam logic [ADDR_W-1:0] ADDR_RECAL     = 10'h004;
    localparam logic [ADDR_W-1:0] ADDR_RAW_BASE  = 10'h00b;
    // Status and bank 3 result offsets
    localparam logic [ADDR_W-1:0] ADDR_PROX_STAT = 10'h020;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_STAT = 10'h021;
    localparam logic [ADDR_W-1:0] ADDR_LOW_STAT  = 10'h022;
    localparam logic [ADDR_W-1:0] ADDR_RES_BASE  = 10'h0e0;

    // Field positions
    localparam int HOLD_FP_LSB  = 0;   // 4 bits
    localparam int HOLD_LP_LSB  = 4;   // 4 bits
    localparam int LVL_REC_LSB  = 0;   // 8 bits
    localparam int LVL_RATE_LSB = 8;   // 6 bits
    localparam int RECAL_FP_LSB = 0;   // 8 bits
    localparam int RECAL_LP_LSB = 8;   // 6 bits

    // Values after reset
    localparam logic [3:0] HOLD_RST  = 4'h0;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [5:0] RATE_RST  = 6'h00;
    localparam logic [7:0] RECAL_RST = 8'h00;

    // Filter shifts and forced recalibration length in conversions
    localparam int         FAST_SHIFT   = 2;
    localparam int         SLOW_SHIFT   = 4;
    localparam logic [1:0] RECAL_CYCLES = 2'h2;

    // Per-stage record kept in the stage memory
    typedef struct packed {
        logic [15:0] raw;        // Latest raw conversion
        logic [15:0] fifoSampleA; // Oldest fast fifo sample
        logic [15:0] fifoSampleB;
        logic [15:0] fifoSampleC; // Newest fast fifo sample
        logic [15:0] fastAvg;    // Fast filter average
        logic [15:0] ambient;    // Stored ambient level
        logic [3:0]  holdCnt;    // Calibration hold countdown
        logic [7:0]  recalCnt;   // Conversions spent in proximity
        logic [1:0]  recalPhase; // Forced recalibration countdown
    } stage_rec_s;

    localparam int REC_W = $bits(stage_rec_s);

    typedef enum {PIPE_IDLE, PIPE_CALC} pipe_state_e;

endpackage : prox_cal_pkg

// ==== rtl/stage_mem_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Write port and two registered read ports of the stage memory
interface stage_mem_if #(
    parameter int WIDTH = 8,
    parameter int AW    = 4
);
    logic             wrEn;
    logic [AW-1:0]    wrAddr;
    logic [WIDTH-1:0] wrData;
    logic [AW-1:0]    rdAddrA;  // Conversion pipeline port
    logic [WIDTH-1:0] rdDataA;
    logic [AW-1:0]    rdAddrB;  // Host read-back port
    logic [WIDTH-1:0] rdDataB;

    modport mem  (input wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
                  output rdDataA, rdDataB);
    modport user (output wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
                  input rdDataA, rdDataB);
endinterface : stage_mem_if
`default_nettype wire

// ==== rtl/stage_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// Per-stage record store; read data leave through registers
module stage_mem
    import prox_cal_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 12,
    parameter int AW    = 4
) (
    input wire logic    clk_sys,
    stage_mem_if.mem    port
);
    logic [WIDTH-1:0] store [DEPTH];  // No reset: contents tracked outside

    // Write, then registered reads on both ports
    always_ff @(posedge clk_sys) begin
        if (port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
        port.rdDataA <= store[port.rdAddrA];
        port.rdDataB <= store[port.rdAddrB];
    end
endmodule : stage_mem
`default_nettype wire

// ==== rtl/proximity_ambient_calibration.sv ====
`timescale 1ns/10ps
`default_nettype none
// Proximity detection and ambient calibration for all stages
module proximity_ambient_calibration
    import prox_cal_pkg::*;
#(
    parameter int          STAGES      = NUM_STAGES,
    parameter logic [15:0] OFFSET_HIGH = 16'h0100,  // Initial high offset
    parameter logic [15:0] OFFSET_LOW  = 16'h0100   // Initial low offset
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // Converter result strobe
    input  wire logic              convValid,
    input  wire logic [3:0]        convStage,
    input  wire logic [15:0]       convData,
    // Mode controls
    input  wire logic              lowPowerMode,
    input  wire logic              slowFilterEn,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic [DATA_W-1:0]      regRdData,
    output logic                   regRdValid,
    // Open-drain interrupt pin, driven low while enabled
    output logic                   intPinOut,
    output logic                   intPinOe,
    // Forced recalibration in progress on any stage
    output logic                   recalBusy
);
    localparam int AW = 4;

    generate
        if (STAGES < 1 || STAGES > 16) begin : g_bad_stages
            $error("STAGES must lie between 1 and 16");
        end
    endgenerate

    stage_mem_if #(.WIDTH(REC_W), .AW(AW)) memIf ();

    stage_mem #(.WIDTH(REC_W), .DEPTH(STAGES), .AW(AW)) u_mem (
        .clk_sys (clk_sys),
        .port    (memIf.mem)
    );

    // Control register fields
    logic [3:0] holdFp, next_holdFp;      // full_power_hold_count
    logic [3:0] holdLp, next_holdLp;      // low_power_hold_count
    logic [7:0] recalLevel, next_recalLevel;  // recal_level_threshold
    logic [5:0] detectRate, next_detectRate;  // approach_rate_threshold
    logic [7:0] recalFp, next_recalFp;    // full_power_forced_recal
    logic [5:0] recalLp, next_recalLp;    // low_power_forced_recal

    // Conversion pipeline state
    pipe_state_e          state, next_state;
    logic [AW-1:0]        curStage, next_curStage;
    logic [15:0]          curData, next_curData;
    logic [STAGES-1:0]    stageInit, next_stageInit;  // Record is valid
    logic [STAGES-1:0]    proxStat, next_proxStat;
    logic [STAGES-1:0]    highStat, next_highStat;
    logic [STAGES-1:0]    lowStat, next_lowStat;
    logic [STAGES-1:0]    recalAct, next_recalAct;

    // Host read pipeline
    logic                 rdPend, next_rdPend;
    logic [ADDR_W-1:0]    rdAddr, next_rdAddr;
    logic [DATA_W-1:0]    next_regRdData;
    logic                 next_regRdValid;
    logic                 next_intPinOe;
    logic                 next_recalBusy;

    // Compute path signals
    stage_rec_s rec, nrec, hostRec;
    logic       prox1, prox2, prox, touched, calOk;
    logic [15:0] hiTh, loTh;
    logic [3:0]  holdLimit;
    logic [7:0]  recalLimit;
    logic [16:0] hiSum;

    // Absolute difference of two unsigned samples
    function automatic logic [15:0] absDiff(input logic [15:0] a,
                                            input logic [15:0] b);
        absDiff = (a >= b) ? a - b : b - a;
    endfunction : absDiff

    // Move a filter value a shifted fraction toward a target
    function automatic logic [15:0] stepToward(input logic [15:0] cur,
                                               input logic [15:0] tgt,
                                               input int sh);
        if (tgt >= cur) begin
            stepToward = cur + ((tgt - cur) >> sh);
        end else begin
            stepToward = cur - ((cur - tgt) >> sh);
        end
    endfunction : stepToward

    // Address decode helpers
    logic rawHit, resHit;
    logic [ADDR_W-1:0] rawOff, resOff;
    assign rawOff = regAddr - ADDR_RAW_BASE;
    assign resOff = regAddr - ADDR_RES_BASE;
    assign rawHit = (regAddr >= ADDR_RAW_BASE)
                    && (rawOff < ADDR_W'(STAGES));
    assign resHit = (regAddr >= ADDR_RES_BASE)
                    && (resOff < ADDR_W'(STAGES));

    // Memory port wiring: pipeline reads on the strobe, host on a read
    always_comb begin
        memIf.rdAddrA = convStage;
        memIf.rdAddrB = rawHit ? rawOff[AW-1:0] : resOff[AW-1:0];
        memIf.wrEn    = (state == PIPE_CALC);
        memIf.wrAddr  = curStage;
        memIf.wrData  = nrec;
        hostRec       = stage_rec_s'(memIf.rdDataB);
    end

    // Per-stage record update for the stage under conversion
    always_comb begin
        rec        = stage_rec_s'(memIf.rdDataA);
        nrec       = rec;
        holdLimit  = lowPowerMode ? holdLp : holdFp;
        recalLimit = lowPowerMode ? {2'h0, recalLp} : recalFp;
        // Thresholds follow the stored ambient level
        hiSum = {1'b0, rec.ambient} + {1'b0, OFFSET_HIGH};
        hiTh  = hiSum[16] ? 16'hffff : hiSum[15:0];
        loTh  = (rec.ambient < OFFSET_LOW) ? 16'h0000
                : rec.ambient - OFFSET_LOW;
        nrec.raw         = curData;
        nrec.fifoSampleA = rec.fifoSampleB;
        nrec.fifoSampleB = rec.fifoSampleC;
        nrec.fifoSampleC = curData;
        nrec.fastAvg     = stepToward(rec.fastAvg, curData, FAST_SHIFT);
        prox1 = absDiff(nrec.fifoSampleA, nrec.fifoSampleC)
                > {10'h000, detectRate};
        prox2 = absDiff(nrec.fastAvg, rec.ambient)
                > {8'h00, recalLevel};
        prox    = prox1 | prox2;
        touched = (curData > hiTh) || (curData < loTh);
        calOk   = 1'b0;
        if (!stageInit[curStage]) begin
            // First conversion seeds the record
            nrec.fifoSampleA = curData;
            nrec.fifoSampleB = curData;
            nrec.fastAvg     = curData;
            nrec.ambient     = curData;
            nrec.holdCnt     = 4'h0;
            nrec.recalCnt    = 8'h00;
            nrec.recalPhase  = 2'h0;
            prox             = 1'b0;
            touched          = 1'b0;
        end else if (rec.recalPhase != 2'h0) begin
            // Forced recalibration runs out over two conversions
            nrec.recalPhase = rec.recalPhase - 2'h1;
            if (rec.recalPhase == 2'h1) begin
                nrec.ambient  = nrec.fastAvg;
                nrec.holdCnt  = 4'h0;
                nrec.recalCnt = 8'h00;
            end
        end else if (prox) begin
            // Calibration stops at once and the hold restarts
            nrec.holdCnt = holdLimit;
            if (recalLimit != 8'h00 && rec.recalCnt + 8'h01 >= recalLimit)
            begin
                nrec.recalPhase = RECAL_CYCLES;
                nrec.recalCnt   = 8'h00;
            end else begin
                nrec.recalCnt = rec.recalCnt + 8'h01;
            end
        end else begin
            nrec.recalCnt = 8'h00;
            if (rec.holdCnt != 4'h0) begin
                nrec.holdCnt = rec.holdCnt - 4'h1;
            end
            // Ambient only learns when idle, untouched and enabled
            calOk = slowFilterEn && (rec.holdCnt == 4'h0)
                    && !touched;
            if (calOk) begin
                nrec.ambient = stepToward(rec.ambient, curData,
                                          SLOW_SHIFT);
            end
        end
    end

    // Pipeline, status and pin next values
    always_comb begin
        next_state     = state;
        next_curStage  = curStage;
        next_curData   = curData;
        next_stageInit = stageInit;
        next_proxStat  = proxStat;
        next_highStat  = highStat;
        next_lowStat   = lowStat;
        next_recalAct  = recalAct;
        unique case (state)
            PIPE_IDLE: begin
                // Strobes for stages beyond the count are dropped
                if (convValid && (convStage < AW'(STAGES))) begin
                    next_curStage = convStage;
                    next_curData  = convData;
                    next_state    = PIPE_CALC;
                end
            end
            PIPE_CALC: begin
                next_stageInit[curStage] = 1'b1;
                next_proxStat[curStage]  = prox;
                next_highStat[curStage]  = curData > hiTh
                                           && stageInit[curStage];
                next_lowStat[curStage]   = curData < loTh
                                           && stageInit[curStage];
                next_recalAct[curStage]  = nrec.recalPhase != 2'h0;
                next_state = PIPE_IDLE;
            end
        endcase
        // Pin pulled low while any stage sits beyond a threshold
        next_intPinOe  = |(next_highStat | next_lowStat);
        next_recalBusy = |next_recalAct;
    end

    // Register writes and host read answers
    always_comb begin
        next_holdFp     = holdFp;
        next_holdLp     = holdLp;
        next_recalLevel = recalLevel;
        next_detectRate = detectRate;
        next_recalFp    = recalFp;
        next_recalLp    = recalLp;
        next_rdPend     = regRead;
        next_rdAddr     = regRead ? regAddr : rdAddr;
        next_regRdValid = rdPend;
        next_regRdData  = regRdData;
        if (regWrite) begin
            unique case (regAddr)
                ADDR_HOLD: begin
                    next_holdFp = regWrData[HOLD_FP_LSB +: 4];
                    next_holdLp = regWrData[HOLD_LP_LSB +: 4];
                end
                ADDR_LEVEL: begin
                    next_recalLevel = regWrData[LVL_REC_LSB +: 8];
                    next_detectRate = regWrData[LVL_RATE_LSB +: 6];
                end
                ADDR_RECAL: begin
                    next_recalFp = regWrData[RECAL_FP_LSB +: 8];
                    next_recalLp = regWrData[RECAL_LP_LSB +: 6];
                end
                default: begin
                    // Read-only or unmapped: write is ignored
                end
            endcase
        end
        if (rdPend) begin
            next_regRdData = '0;
            if (rdAddr == ADDR_HOLD) begin
                next_regRdData[HOLD_FP_LSB +: 4] = holdFp;
                next_regRdData[HOLD_LP_LSB +: 4] = holdLp;
            end else if (rdAddr == ADDR_LEVEL) begin
                next_regRdData[LVL_REC_LSB +: 8]  = recalLevel;
                next_regRdData[LVL_RATE_LSB +: 6] = detectRate;
            end else if (rdAddr == ADDR_RECAL) begin
                next_regRdData[RECAL_FP_LSB +: 8] = recalFp;
                next_regRdData[RECAL_LP_LSB +: 6] = recalLp;
            end else if (rdAddr == ADDR_PROX_STAT) begin
                next_regRdData[STAGES-1:0] = proxStat;
            end else if (rdAddr == ADDR_HIGH_STAT) begin
                next_regRdData[STAGES-1:0] = highStat;
            end else if (rdAddr == ADDR_LOW_STAT) begin
                next_regRdData[STAGES-1:0] = lowStat;
            end else if ((rdAddr >= ADDR_RAW_BASE)
                && (rdAddr - ADDR_RAW_BASE < ADDR_W'(STAGES))) begin
                next_regRdData = memIf.rdDataB[REC_W-1 -: 16];
            end else if ((rdAddr >= ADDR_RES_BASE)
                && (rdAddr - ADDR_RES_BASE < ADDR_W'(STAGES))) begin
                // Bank 3 result: fast filter average of the stage
                next_regRdData = hostRec.fastAvg;
            end
        end
    end

    // Register every piece of state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            holdFp     <= HOLD_RST;
            holdLp     <= HOLD_RST;
            recalLevel <= LEVEL_RST;
            detectRate <= RATE_RST;
            recalFp    <= RECAL_RST;
            recalLp    <= RECAL_RST[5:0];
            state      <= PIPE_IDLE;
            curStage   <= '0;
            curData    <= '0;
            stageInit  <= '0;
            proxStat   <= '0;
            highStat   <= '0;
            lowStat    <= '0;
            recalAct   <= '0;
            rdPend     <= 1'b0;
            rdAddr     <= '0;
            regRdData  <= '0;
            regRdValid <= 1'b0;
            intPinOut  <= 1'b0;
            intPinOe   <= 1'b0;
            recalBusy  <= 1'b0;
        end else begin
            holdFp     <= next_holdFp;
            holdLp     <= next_holdLp;
            recalLevel <= next_recalLevel;
            detectRate <= next_detectRate;
            recalFp    <= next_recalFp;
            recalLp    <= next_recalLp;
            state      <= next_state;
            curStage   <= next_curStage;
            curData    <= next_curData;
            stageInit  <= next_stageInit;
            proxStat   <= next_proxStat;
            highStat   <= next_highStat;
            lowStat    <= next_lowStat;
            recalAct   <= next_recalAct;
            rdPend     <= next_rdPend;
            rdAddr     <= next_rdAddr;
            regRdData  <= next_regRdData;
            regRdValid <= next_regRdValid;
            intPinOut  <= 1'b0;  // Open drain: only ever pulls low
            intPinOe   <= next_intPinOe;
            recalBusy  <= next_recalBusy;
        end
    end

endmodule : proximity_ambient_calibration
`default_nettype wire

// ==== tb/prox_cal_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the calibration block
module prox_cal_props
    import prox_cal_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst_b,
    input wire logic              convValid,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic              regRdValid,
    input wire logic              intPinOut,
    input wire logic              intPinOe,
    input wire logic              recalBusy
);
    // One clock domain, one reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // Read answer lands two edges after the taking edge
    sequence s_answer;
        ##2 regRdValid;
    endsequence
    // Status outputs move only as a result of a conversion
    sequence s_conv_cause;
        $past(convValid, 2);
    endsequence

    chk_read_answer: assert property (regRead |-> s_answer)
        else $error("read got no answer");
    chk_valid_cause: assert property (regRdValid |-> $past(regRead, 2))
        else $error("answer without a read");
    chk_data_hold: assert property (!regRdValid |-> $stable(regRdData))
        else $error("read data moved between answers");
    chk_write_silent: assert property (regWrite && !regRead |-> ##2 !regRdValid)
        else $error("write produced an answer");
    chk_pin_quiet: assert property (intPinOut == 1'b0)
        else $error("open drain pin driven high");
    chk_int_cause: assert property ($changed(intPinOe) |-> s_conv_cause)
        else $error("interrupt moved without conversion");
    chk_busy_start: assert property ($rose(recalBusy) |-> s_conv_cause)
        else $error("recalibration began without conversion");
    chk_busy_end: assert property ($fell(recalBusy) |-> s_conv_cause)
        else $error("recalibration ended without conversion");
endmodule : prox_cal_props

// Attached to every instance of the block
bind proximity_ambient_calibration prox_cal_props u_props (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .convValid  (convValid),
    .regWrite   (regWrite),
    .regRead    (regRead),
    .regRdData  (regRdData),
    .regRdValid (regRdValid),
    .intPinOut  (intPinOut),
    .intPinOe   (intPinOe),
    .recalBusy  (recalBusy)
);
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Host on the register strobe port
module host_model
    import prox_cal_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              recalBusy,
    input  wire logic [DATA_W-1:0] regRdData,
    input  wire logic              regRdValid,
    output logic      [ADDR_W-1:0] regAddr,
    output logic      [DATA_W-1:0] regWrData,
    output logic                   regWrite,
    output logic                   regRead
);
    // Idle bus, address parked on an unmapped word
    initial begin
        regAddr = 10'h3ff;
        regWrData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // Stay off the bus while a recalibration runs; bounded
    task automatic wait_idle();
        for (int i = 0; i < 64 && recalBusy !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
    endtask : wait_idle

    // One-cycle write strobe; data then shows no stale value
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        wait_idle();
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWrData <= ~d;
    endtask : wr

    // Read: answer is settled after the second edge past the strobe
    task automatic rd(input logic [9:0] a, output logic [15:0] d,
                      output logic v);
        wait_idle();
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        #1;
        v = regRdValid;
        d = regRdData;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ==== tb/proximity_ambient_calibration_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for proximity detection and calibration
module proximity_ambient_calibration_tb
    import prox_cal_pkg::*;
;
    logic              clk_sys = 1'b0;      // 100 ns period
    logic              rst_b = 1'b0;        // Held for four cycles
    logic              convValid = 1'b0;    // Converter strobe
    logic [3:0]        convStage = 4'h0;
    logic [15:0]       convData = 16'h0000;
    logic              lowPowerMode = 1'b0;
    logic              slowFilterEn = 1'b1; // Ambient tracking on
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic [DATA_W-1:0] regRdData;
    logic              regWrite;
    logic              regRead;
    logic              regRdValid;
    logic              intPinOut;
    logic              intPinOe;
    logic              recalBusy;
    int                nFail = 0;
    int                checkCount = 0;
    int                cycles = 0;

    always #50 clk_sys = ~clk_sys;

    proximity_ambient_calibration u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .convValid(convValid),
        .convStage(convStage), .convData(convData),
        .lowPowerMode(lowPowerMode), .slowFilterEn(slowFilterEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData),
        .regRdValid(regRdValid), .intPinOut(intPinOut),
        .intPinOe(intPinOe), .recalBusy(recalBusy));

    host_model u_host (
        .clk_sys(clk_sys), .recalBusy(recalBusy), .regRdData(regRdData),
        .regRdValid(regRdValid), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));

    // Compare a word result
    task automatic chkW(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
        end
    endtask : chkW

    // Compare a single flag
    task automatic chkB(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chkB

    // Read a register and judge both the strobe and the word
    task automatic rdChk(input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        u_host.rd(a, d, v);
        chkB(v, 1'b1);
        chkW(d, exp);
    endtask : rdChk

    // One conversion; waits out the two-edge answer plus margin
    task automatic conv(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk_sys);
        convValid <= 1'b1;
        convStage <= s;
        convData <= d;
        @(posedge clk_sys);
        convValid <= 1'b0;
        convData <= ~d;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : conv

    // Control words reset to zero and mask their unused bits
    task automatic t_regs();
        logic [15:0] mask [3] = '{16'h00ff, 16'h3fff, 16'h3fff};
        for (int i = 0; i < 3; i++) begin
            rdChk(ADDR_HOLD + 10'(i), 16'h0000);
            u_host.wr(ADDR_HOLD + 10'(i), 16'hffff);
            rdChk(ADDR_HOLD + 10'(i), mask[i]);
        end
        rdChk(10'h3ff, 16'h0000);
    endtask : t_regs

    // Seed every stage; raw and bank-3 words read back
    task automatic t_raw();
        for (int s = 0; s < NUM_STAGES; s++) begin
            conv(4'(s), 16'h2000 + 16'(s));
            rdChk(ADDR_RAW_BASE + 10'(s), 16'h2000 + 16'(s));
            rdChk(ADDR_RES_BASE + 10'(s), 16'h2000 + 16'(s));
        end
        u_host.wr(ADDR_RAW_BASE, 16'h0000);
        rdChk(ADDR_RAW_BASE, 16'h2000);
        chkB(intPinOe, 1'b0);
    endtask : t_raw

    // Rate comparator at its boundary, then level comparator
    task automatic t_prox();
        u_host.wr(ADDR_HOLD, 16'h0000);
        u_host.wr(ADDR_RECAL, 16'h0000);
        u_host.wr(ADDR_LEVEL, 16'h04ff);
        conv(4'h0, 16'h2004);
        rdChk(ADDR_PROX_STAT, 16'h0000);
        conv(4'h0, 16'h2005);
        rdChk(ADDR_PROX_STAT, 16'h0001);
        u_host.wr(ADDR_LEVEL, 16'h3f02);
        conv(4'h1, 16'h2011);
        rdChk(ADDR_PROX_STAT, 16'h0003);
    endtask : t_prox

    // High limit raises the pin, low limit sets its flag; clean results drop it
    task automatic t_thresh();
        conv(4'h2, 16'h2103);
        rdChk(ADDR_HIGH_STAT, 16'h0004);
        chkB(intPinOe, 1'b1);
        conv(4'h4, 16'h1f03);
        rdChk(ADDR_LOW_STAT, 16'h0010);
        conv(4'h2, 16'h2002);
        conv(4'h4, 16'h2004);
        rdChk(ADDR_HIGH_STAT, 16'h0000);
        chkB(intPinOe, 1'b0);
    endtask : t_thresh

    // Low power hover forces a two-conversion recalibration
    task automatic t_recal();
        logic busyExp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        u_host.wr(ADDR_LEVEL, 16'h0000);
        u_host.wr(ADDR_RECAL, 16'h0200);
        lowPowerMode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            conv(4'h5, 16'h2105);
            chkB(recalBusy, busyExp[i]);
        end
        rdChk(ADDR_RES_BASE + 10'h005, 16'h20b4);
        // New ambient lifts the high limit past this sample
        conv(4'h5, 16'h2106);
        rdChk(ADDR_HIGH_STAT, 16'h0000);
    endtask : t_recal

    // Hold delays ambient tracking; high-limit probes read it back
    task automatic t_hold();
        u_host.wr(ADDR_LEVEL, 16'h3fff);
        u_host.wr(ADDR_HOLD, 16'h0002);
        lowPowerMode <= 1'b0;
        conv(4'h6, 16'h2060);
        repeat (3) conv(4'h6, 16'h2040);
        conv(4'h6, 16'h2109);
        chkB(intPinOe, 1'b0);
        conv(4'h6, 16'h210a);
        chkB(intPinOe, 1'b1);
    endtask : t_hold

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d failures %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nFail++;
            test_done();
        end
    end

    // Reset, then the scenarios in order
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_raw();
        t_prox();
        t_thresh();
        t_recal();
        t_hold();
        test_done();
    end
endmodule : proximity_ambient_calibration_tb
`default_nettype wire
